// file: design/pldcr_pkg.sv
// constants for the link power timer and phy training diagnostic register bank
// Behaviour
// - common clock set: report separate-clock Reported_a
// - common clock clear: report shared-clock Reported_a
// - upper bits 31:21 read zero, ignore writes
// - mask bit blocks secondary bus reset
// - L1 entry delay in 512 ns ticks
// - L0s entry delay in 62.5 MHz ticks
// - common clock clear: separate-clock FTS count used
// - common clock set: shared-clock FTS count used
// - L2 power saving only when enabled
// - second BAR responds only when enabled
// - first BAR responds only when enabled
// - marked fields reset only by fundamental reset
// - fundamental reset from pcie or global reset
package pldcr_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] TIMER_REG_OFS = 8'hc4;
   localparam logic [7:0] PHY_REG_OFS = 8'hc8;
   localparam logic [31:0] TIMER_REG_RST = 32'h00120108;
   localparam logic [31:0] PHY_REG_RST = 32'h32142000;
   // writable bits of each word, rest read as zero or as the phy revision input
   localparam logic [31:0] TIMER_WR_MASK = 32'h001fffff;
   localparam logic [31:0] PHY_FUNDAMENTAL_RESET_N_MASK = 32'hffff1f00;
   localparam logic [31:0] PHY_SYS_MASK = 32'h000000ff;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int L1_SEP_LSB = 18;
   localparam int L1_SHR_LSB = 15;
   localparam int SEC_MASK_BIT = 10;
   localparam int L1_TMR_LSB = 6;
   localparam int L0S_TMR_LSB = 2;
   localparam int FTS_SEP_LSB = 24;
   localparam int FTS_SHR_LSB = 16;
   localparam int PHY_REVISION_FIELD_LSB = 13;
   localparam int LINK_NUM_LSB = 8;
   localparam int L2_SAVE_BIT = 7;
   localparam int BAR1_BIT = 6;
   localparam int BAR0_BIT = 5;
   localparam int REQ_LSB = 0;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int L1_TICK_NS = 512;
   localparam int L0S_TICK_NS = 16;
   // least times, so round up
   localparam int L1_TICK_CYC = (L1_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int L0S_TICK_CYC = (L0S_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] L1_PRE_LAST = 6'(L1_TICK_CYC - 1);
   localparam logic [5:0] L0S_PRE_LAST = 6'(L0S_TICK_CYC - 1);
endpackage

// file: design/pldcr_regs.sv
// link power timer and phy training diagnostic register bank
`timescale 1ns/1ns
module pldcr_regs (
   // clock and resets
   input wire logic CLK_SYS_IN,
   input wire logic RSTN_IN,
   input wire logic PCIE_RESET_N_IN,
   input wire logic GLOBAL_RESET_N_IN,
   output logic FUNDAMENTAL_RESET_N_OUT,
   // configuration access
   input wire logic CFG_WR_IN,
   input wire logic CFG_RD_IN,
   input wire logic [7:0] CFG_ADDR_IN,
   input wire logic [3:0] CFG_BE_IN,
   input wire logic [31:0] CFG_WDATA_IN,
   output logic [31:0] CFG_RDATA_OUT,
   output logic CFG_ACK_OUT,
   // link status
   input wire logic COMMON_CLOCK_CONFIG_BIT_IN,
   input wire logic SECONDARY_RESET_BIT_IN,
   input wire logic LINK_IDLE_IN,
   input wire logic LINK_IN_L2_IN,
   input wire logic [2:0] PHY_REVISION_FIELD_IN,
   // link controls
   output logic [2:0] REPORTED_A_OUT,
   output logic [7:0] FTS_COUNT_OUT,
   output logic SECONDARY_BUS_RESET_OUT,
   output logic L1_ENTRY_DUE_OUT,
   output logic L0S_ENTRY_DUE_OUT,
   output logic L2_POWER_SAVING_OUT,
   output logic FIRST_BAR_ENABLE_OUT,
   output logic SECOND_BAR_ENABLE_OUT,
   output logic [4:0] LINK_NUMBER_OUT,
   output logic RECOVERY_REQUEST_OUT,
   output logic RECONFIGURE_REQUEST_OUT,
   output logic HOT_RESET_REQUEST_OUT,
   output logic SCRAMBLER_DISABLE_REQUEST_OUT,
   output logic LOOPBACK_REQUEST_OUT
);
   import pldcr_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   // fields held through ordinary reset live apart from the rest
   typedef struct packed {
      logic [31:0] timer_word;
      logic [31:0] phy_word;
   } pldcr_fundamental_reset_n_t;

   typedef struct packed {
      logic [7:0] phy_low;
      logic [31:0] rdata;
      logic ack;
      logic [5:0] l1_pre;
      logic [3:0] l1_cnt;
      logic [5:0] l0s_pre;
      logic [3:0] l0s_cnt;
   } pldcr_sys_t;

   pldcr_fundamental_reset_n_t fundamental_reset_n_q;
   pldcr_fundamental_reset_n_t fundamental_reset_n_d;
   pldcr_sys_t sys_q;
   pldcr_sys_t sys_d;
   logic fundamental_reset_n_n;
   logic sys_rst_n;
   logic hit_timer;
   logic hit_phy;
   logic [3:0] l1_limit;
   logic [3:0] l0s_limit;
   logic [31:0] phy_low_merged;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // byte-enable merge restricted to writable bits
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] wmask);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
      return (old & ~m) | (wd & m);
   endfunction

   // one entry timer step: prescaler wraps into a saturating tick count
   function automatic logic [9:0] tmr_step(input logic idle, input logic [5:0] pre,
                                           input logic [3:0] cnt, input logic [3:0] lim,
                                           input logic [5:0] last);
      logic [5:0] p;
      logic [3:0] c;
      p = 6'h00;
      c = 4'h0;
      if (idle) begin
         p = (pre == last) ? 6'h00 : pre + 6'h01;
         c = (pre == last && cnt != lim) ? cnt + 4'h1 : cnt;
      end
      return {p, c};
   endfunction

   // ---------------------------------------------------------------
   // resets and decode
   // ---------------------------------------------------------------
   assign fundamental_reset_n_n = PCIE_RESET_N_IN & GLOBAL_RESET_N_IN;
   // any fundamental reset also clears the ordinary-reset fields
   assign sys_rst_n = RSTN_IN & fundamental_reset_n_n;
   assign hit_timer = (CFG_ADDR_IN[7:2] == TIMER_REG_OFS[7:2]);
   assign hit_phy = (CFG_ADDR_IN[7:2] == PHY_REG_OFS[7:2]);
   assign l1_limit = fundamental_reset_n_q.timer_word[L1_TMR_LSB +: 4];
   assign l0s_limit = fundamental_reset_n_q.timer_word[L0S_TMR_LSB +: 4];
   // a function result cannot be sliced directly, so widen through a net
   assign phy_low_merged = merge({24'h000000, sys_q.phy_low}, CFG_WDATA_IN, CFG_BE_IN,
                                 PHY_SYS_MASK);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // reads return the value before a same-cycle write
   always_comb begin
      fundamental_reset_n_d = fundamental_reset_n_q;
      sys_d = sys_q;
      if (CFG_WR_IN && hit_timer) begin
         // bits 31:21 never stored
         fundamental_reset_n_d.timer_word = merge(fundamental_reset_n_q.timer_word, CFG_WDATA_IN, CFG_BE_IN,
                                   TIMER_WR_MASK);
      end
      if (CFG_WR_IN && hit_phy) begin
         // revision bits stay out of storage
         fundamental_reset_n_d.phy_word = merge(fundamental_reset_n_q.phy_word, CFG_WDATA_IN, CFG_BE_IN, PHY_FUNDAMENTAL_RESET_N_MASK);
         sys_d.phy_low = phy_low_merged[7:0];
      end
      sys_d.ack = CFG_WR_IN | CFG_RD_IN;
      if (CFG_RD_IN) begin
         if (hit_timer) begin
            sys_d.rdata = fundamental_reset_n_q.timer_word & TIMER_WR_MASK;
         end else if (hit_phy) begin
            sys_d.rdata = fundamental_reset_n_q.phy_word | {16'h0000, PHY_REVISION_FIELD_IN, 13'h0000}
                          | {24'h000000, sys_q.phy_low};
         end else begin
            sys_d.rdata = 32'h00000000;
         end
      end
      {sys_d.l1_pre, sys_d.l1_cnt} = tmr_step(LINK_IDLE_IN, sys_q.l1_pre, sys_q.l1_cnt,
                                              l1_limit, L1_PRE_LAST);
      {sys_d.l0s_pre, sys_d.l0s_cnt} = tmr_step(LINK_IDLE_IN, sys_q.l0s_pre, sys_q.l0s_cnt,
                                                l0s_limit, L0S_PRE_LAST);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // fields that survive every reset but the fundamental one
   always_ff @(posedge CLK_SYS_IN or negedge fundamental_reset_n_n) begin
      if (!fundamental_reset_n_n) begin
         fundamental_reset_n_q <= '{timer_word: TIMER_REG_RST, phy_word: PHY_REG_RST & PHY_FUNDAMENTAL_RESET_N_MASK};
      end else begin
         fundamental_reset_n_q <= fundamental_reset_n_d;
      end
   end

   // controls, access and timers cleared by either reset
   always_ff @(posedge CLK_SYS_IN or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         sys_q <= '{phy_low: PHY_REG_RST[7:0], rdata: 32'h00000000, ack: 1'b0,
                    l1_pre: 6'h00, l1_cnt: 4'h0, l0s_pre: 6'h00, l0s_cnt: 4'h0};
      end else begin
         sys_q <= sys_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign FUNDAMENTAL_RESET_N_OUT = fundamental_reset_n_n;
   assign CFG_RDATA_OUT = sys_q.rdata;
   assign CFG_ACK_OUT = sys_q.ack;
   // mode input selects which stored value the capability register shows
   assign REPORTED_A_OUT = COMMON_CLOCK_CONFIG_BIT_IN
                           ? fundamental_reset_n_q.timer_word[L1_SEP_LSB +: 3]
                           : fundamental_reset_n_q.timer_word[L1_SHR_LSB +: 3];
   assign FTS_COUNT_OUT = COMMON_CLOCK_CONFIG_BIT_IN
                          ? fundamental_reset_n_q.phy_word[FTS_SHR_LSB +: 8]
                          : fundamental_reset_n_q.phy_word[FTS_SEP_LSB +: 8];
   assign SECONDARY_BUS_RESET_OUT = SECONDARY_RESET_BIT_IN
                                    & ~fundamental_reset_n_q.timer_word[SEC_MASK_BIT];
   // a zero limit means entry is due from the first idle cycle
   assign L1_ENTRY_DUE_OUT = LINK_IDLE_IN && sys_q.l1_cnt == l1_limit;
   assign L0S_ENTRY_DUE_OUT = LINK_IDLE_IN && sys_q.l0s_cnt == l0s_limit;
   assign L2_POWER_SAVING_OUT = LINK_IN_L2_IN & sys_q.phy_low[L2_SAVE_BIT];
   assign SECOND_BAR_ENABLE_OUT = sys_q.phy_low[BAR1_BIT];
   assign FIRST_BAR_ENABLE_OUT = sys_q.phy_low[BAR0_BIT];
   assign LINK_NUMBER_OUT = fundamental_reset_n_q.phy_word[LINK_NUM_LSB +: 5];
   // low five bits go straight to the training state machine
   assign RECOVERY_REQUEST_OUT = sys_q.phy_low[REQ_LSB + 4];
   assign RECONFIGURE_REQUEST_OUT = sys_q.phy_low[REQ_LSB + 3];
   assign HOT_RESET_REQUEST_OUT = sys_q.phy_low[REQ_LSB + 2];
   assign SCRAMBLER_DISABLE_REQUEST_OUT = sys_q.phy_low[REQ_LSB + 1];
   assign LOOPBACK_REQUEST_OUT = sys_q.phy_low[REQ_LSB];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // consecutive idle cycles, saturating, for the l1 entry timer check
   logic [15:0] idle_run_q;
   always_ff @(posedge CLK_SYS_IN or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         idle_run_q <= 16'h0000;
      end else if (!LINK_IDLE_IN) begin
         idle_run_q <= 16'h0000;
      end else if (idle_run_q != 16'hffff) begin
         idle_run_q <= idle_run_q + 16'h0001;
      end
   end

   sequence s_rd_timer;
      CFG_RD_IN && hit_timer;
   endsequence
   sequence s_rd_phy;
      CFG_RD_IN && hit_phy;
   endsequence

   property p_lat_sep;
      @(posedge CLK_SYS_IN) disable iff (!fundamental_reset_n_n)
      COMMON_CLOCK_CONFIG_BIT_IN |-> REPORTED_A_OUT == fundamental_reset_n_q.timer_word[20:18];
   endproperty
   a_lat_sep: assert property (p_lat_sep) else $error("reported_a not separate field");

   property p_lat_shr;
      @(posedge CLK_SYS_IN) disable iff (!fundamental_reset_n_n)
      !COMMON_CLOCK_CONFIG_BIT_IN |-> REPORTED_A_OUT == fundamental_reset_n_q.timer_word[17:15];
   endproperty
   a_lat_shr: assert property (p_lat_shr) else $error("reported_a not shared field");

   property p_rsvd_zero;
      @(posedge CLK_SYS_IN) disable iff (!sys_rst_n)
      s_rd_timer |=> CFG_ACK_OUT && CFG_RDATA_OUT[31:21] == 11'h000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

   property p_sec_rst;
      @(posedge CLK_SYS_IN) disable iff (!fundamental_reset_n_n)
      fundamental_reset_n_q.timer_word[10] |-> !SECONDARY_BUS_RESET_OUT;
   endproperty
   a_sec_rst: assert property (p_sec_rst) else $error("secondary reset not masked");

   property p_l1_due;
      @(posedge CLK_SYS_IN) disable iff (!sys_rst_n)
      L1_ENTRY_DUE_OUT && $stable(l1_limit) |-> idle_run_q >= 16'(l1_limit * 52);
   endproperty
   a_l1_due: assert property (p_l1_due) else $error("l1 entry due too early");

   property p_l0s_due;
      @(posedge CLK_SYS_IN) disable iff (!sys_rst_n)
      LINK_IDLE_IN && l0s_limit == 4'h2 && !L0S_ENTRY_DUE_OUT ##1 LINK_IDLE_IN[*4]
      |-> L0S_ENTRY_DUE_OUT || $changed(l0s_limit);
   endproperty
   a_l0s_due: assert property (p_l0s_due) else $error("l0s entry late");

   property p_fts;
      @(posedge CLK_SYS_IN) disable iff (!fundamental_reset_n_n)
      FTS_COUNT_OUT == (COMMON_CLOCK_CONFIG_BIT_IN ? fundamental_reset_n_q.phy_word[23:16]
                                                   : fundamental_reset_n_q.phy_word[31:24]);
   endproperty
   a_fts: assert property (p_fts) else $error("fts count wrong source");

   property p_l2;
      @(posedge CLK_SYS_IN) disable iff (!sys_rst_n)
      L2_POWER_SAVING_OUT |-> LINK_IN_L2_IN && sys_q.phy_low[7];
   endproperty
   a_l2: assert property (p_l2) else $error("l2 saving while disabled");

   property p_bar;
      @(posedge CLK_SYS_IN) disable iff (!sys_rst_n)
      s_rd_phy |=> CFG_RDATA_OUT[6:5] == $past({SECOND_BAR_ENABLE_OUT, FIRST_BAR_ENABLE_OUT});
   endproperty
   a_bar: assert property (p_bar) else $error("bar enable mismatch");

   property p_keep;
      @(posedge CLK_SYS_IN) disable iff (!fundamental_reset_n_n)
      !RSTN_IN && !CFG_WR_IN |=> $stable(fundamental_reset_n_q);
   endproperty
   a_keep: assert property (p_keep) else $error("field lost on ordinary reset");

   property p_fundamental_reset_n;
      @(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
      FUNDAMENTAL_RESET_N_OUT == (PCIE_RESET_N_IN && GLOBAL_RESET_N_IN);
   endproperty
   a_fundamental_reset_n: assert property (p_fundamental_reset_n) else $error("fundamental reset wrong");

   property p_req;
      @(posedge CLK_SYS_IN) disable iff (!sys_rst_n)
      CFG_WR_IN && hit_phy && CFG_BE_IN[0] |=> LOOPBACK_REQUEST_OUT == $past(CFG_WDATA_IN[0])
      && RECOVERY_REQUEST_OUT == $past(CFG_WDATA_IN[4]);
   endproperty
   a_req: assert property (p_req) else $error("request bits not written");

   property p_rev;
      @(posedge CLK_SYS_IN) disable iff (!sys_rst_n)
      s_rd_phy |=> CFG_RDATA_OUT[15:13] == $past(PHY_REVISION_FIELD_IN);
   endproperty
   a_rev: assert property (p_rev) else $error("phy revision not read-only");
endmodule // pldcr_regs

// file: test/pcie_link_diag_control_regs_test.sv
// self-checking bench for the link power timer and phy training diagnostic register bank
`timescale 1ns/1ns
module pcie_link_diag_control_regs_test;
   import pldcr_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic pcie_n = 1'b0;
   logic glob_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [3:0] be = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic ccc = 1'b0;
   logic sec_rst = 1'b0;
   logic idle = 1'b0;
   logic in_l2 = 1'b0;
   logic [2:0] phy_revision_field = 3'h5;
   logic fundamental_reset_n_n, ack, sbr, l1_due, l0s_due, l2_save, bar0, bar1;
   logic rq_rec, rq_cfg, rq_hot, rq_scr, rq_lb;
   logic [31:0] rdata;
   logic [2:0] rep;
   logic [7:0] fts;
   logic [4:0] link_num;
   int bad_count = 0;
   int compares = 0;
   // 100 MHz system clock
   always #5 clk = ~clk;
   pldcr_regs u_dut (
      .CLK_SYS_IN(clk), .RSTN_IN(rstn), .PCIE_RESET_N_IN(pcie_n),
      .GLOBAL_RESET_N_IN(glob_n), .FUNDAMENTAL_RESET_N_OUT(fundamental_reset_n_n),
      .CFG_WR_IN(wr), .CFG_RD_IN(rd), .CFG_ADDR_IN(addr), .CFG_BE_IN(be),
      .CFG_WDATA_IN(wdata), .CFG_RDATA_OUT(rdata), .CFG_ACK_OUT(ack),
      .COMMON_CLOCK_CONFIG_BIT_IN(ccc), .SECONDARY_RESET_BIT_IN(sec_rst),
      .LINK_IDLE_IN(idle), .LINK_IN_L2_IN(in_l2), .PHY_REVISION_FIELD_IN(phy_revision_field),
      .REPORTED_A_OUT(rep), .FTS_COUNT_OUT(fts), .SECONDARY_BUS_RESET_OUT(sbr),
      .L1_ENTRY_DUE_OUT(l1_due), .L0S_ENTRY_DUE_OUT(l0s_due),
      .L2_POWER_SAVING_OUT(l2_save), .FIRST_BAR_ENABLE_OUT(bar0),
      .SECOND_BAR_ENABLE_OUT(bar1), .LINK_NUMBER_OUT(link_num),
      .RECOVERY_REQUEST_OUT(rq_rec), .RECONFIGURE_REQUEST_OUT(rq_cfg),
      .HOT_RESET_REQUEST_OUT(rq_hot), .SCRAMBLER_DISABLE_REQUEST_OUT(rq_scr),
      .LOOPBACK_REQUEST_OUT(rq_lb)
   );
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // sample one step after the edge so its updates have landed
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one-cycle strobe, ack expected exactly one cycle later
   task automatic wr_reg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      be <= b;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
      chk("write ack", 32'h1, {31'h0, ack});
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("read ack", 32'h1, {31'h0, ack});
      chk(name, exp, rdata);
   endtask
   task automatic stop_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values;
      rd_reg(TIMER_REG_OFS, TIMER_REG_RST, "timer reg");
      rd_reg(PHY_REG_OFS, 32'h3214a000, "phy reg");
      rd_reg(8'hc0, 32'h0, "unmapped read");
      chk("latency", 32'h4, {29'h0, rep});
      chk("fts", 32'h32, {24'h0, fts});
      chk("bars", 32'h0, {30'h0, bar1, bar0});
      $display("done reset values");
   endtask
   task automatic t_clock_mode;
      wr_reg(TIMER_REG_OFS, 4'hf, 32'h000e8108);
      chk("latency shared", 32'h5, {29'h0, rep});
      chk("fts separate", 32'h32, {24'h0, fts});
      @(posedge clk);
      ccc <= 1'b1;
      step(1);
      chk("latency separate", 32'h3, {29'h0, rep});
      chk("fts shared", 32'h14, {24'h0, fts});
      $display("done clock mode");
   endtask
   task automatic t_reset_mask;
      @(posedge clk);
      sec_rst <= 1'b1;
      step(1);
      chk("bus reset open", 32'h1, {31'h0, sbr});
      wr_reg(TIMER_REG_OFS, 4'h2, 32'h00000500);
      chk("bus reset masked", 32'h0, {31'h0, sbr});
      wr_reg(TIMER_REG_OFS, 4'h2, 32'h00000100);
      chk("bus reset again", 32'h1, {31'h0, sbr});
      $display("done reset mask");
   endtask
   // limits 2 and 4: due after 2*2 and 4*52 idle edges
   task automatic t_entry_timers;
      @(posedge clk);
      idle <= 1'b1;
      step(3);
      chk("l0s early", 32'h0, {31'h0, l0s_due});
      step(1);
      chk("l0s due", 32'h1, {31'h0, l0s_due});
      step(4 * L1_TICK_CYC - 5);
      chk("l1 early", 32'h0, {31'h0, l1_due});
      step(1);
      chk("l1 due", 32'h1, {31'h0, l1_due});
      @(posedge clk);
      idle <= 1'b0;
      #1;
      chk("dues drop", 32'h0, {30'h0, l1_due, l0s_due});
      $display("done entry timers");
   endtask
   task automatic t_phy_controls;
      wr_reg(PHY_REG_OFS, 4'h1, 32'h00000015);
      chk("requests", 32'h15, {27'h0, rq_rec, rq_cfg, rq_hot, rq_scr, rq_lb});
      chk("bars off", 32'h0, {30'h0, bar1, bar0});
      wr_reg(PHY_REG_OFS, 4'h1, 32'h000000ea);
      chk("requests swap", 32'h0a, {27'h0, rq_rec, rq_cfg, rq_hot, rq_scr, rq_lb});
      chk("bars on", 32'h3, {30'h0, bar1, bar0});
      chk("l2 save out of l2", 32'h0, {31'h0, l2_save});
      @(posedge clk);
      in_l2 <= 1'b1;
      step(1);
      chk("l2 save in l2", 32'h1, {31'h0, l2_save});
      wr_reg(PHY_REG_OFS, 4'h2, 32'h0000ff00);
      chk("link number", 32'h1f, {27'h0, link_num});
      rd_reg(PHY_REG_OFS, 32'h3214bfea, "phy reg");
      $display("done phy controls");
   endtask
   task automatic t_reset_domains;
      // reserved rw bits 14:11 and 1:0 always written as zero
      wr_reg(TIMER_REG_OFS, 4'hf, 32'hffff87fc);
      rd_reg(TIMER_REG_OFS, 32'h001f87fc, "timer upper zero");
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(TIMER_REG_OFS, 32'h001f87fc, "timer kept");
      rd_reg(PHY_REG_OFS, 32'h3214bf00, "phy kept");
      chk("l2 save disabled", 32'h0, {31'h0, l2_save});
      chk("requests cleared", 32'h0, {27'h0, rq_rec, rq_cfg, rq_hot, rq_scr, rq_lb});
      for (int i = 0; i < 2; i++) begin
         wr_reg(TIMER_REG_OFS, 4'hf, 32'h001f87fc);
         @(posedge clk);
         pcie_n <= (i == 0);
         glob_n <= (i != 0);
         #1;
         chk("fundamental reset", 32'h0, {31'h0, fundamental_reset_n_n});
         @(posedge clk);
         pcie_n <= 1'b1;
         glob_n <= 1'b1;
         rd_reg(TIMER_REG_OFS, TIMER_REG_RST, "timer cleared");
      end
      rd_reg(PHY_REG_OFS, 32'h3214a000, "phy cleared");
      $display("done reset domains");
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      pcie_n <= 1'b1;
      glob_n <= 1'b1;
      t_reset_values();
      t_clock_mode();
      t_reset_mask();
      t_entry_timers();
      t_phy_controls();
      t_reset_domains();
      stop_test();
   end
   // whole run is under 300 cycles, so this only trips on a hang
   initial begin
      #100000;
      bad_count++;
      stop_test();
   end
endmodule // pcie_link_diag_control_regs_test
